// File: hw/cmp_pkg.sv
package cmp_pkg;

    // register byte addresses (offsets as printed)
    localparam logic [15:0] ctrl_status_addr = 16'h108c;
    localparam logic [15:0] edge_ctrl_addr = 16'h108d;
    localparam logic [15:0] neg_sel_addr = 16'h108e;
    localparam logic [15:0] pos_sel_addr = 16'h108f;
    localparam logic [15:0] mirror_addr = 16'h109f;
    localparam logic [15:0] irq_ctrl_addr = 16'h10a0;
    localparam logic [15:0] adc_trig_addr = 16'h10a4;

    // control register 0 fields
    localparam int en_bit = 7;
    localparam int out_bit = 6;
    localparam int inv_bit = 4;
    localparam int sep_bit = 1;
    localparam int sync_bit = 0;
    // control register 1 fields
    localparam int rise_bit = 1;
    localparam int fall_bit = 0;
    // irq control fields
    localparam int flag_bit = 0;
    localparam int ie_bit = 1;
    localparam int gie_bit = 2;
    localparam int sleep_bit = 3;

    localparam logic [7:0] ctrl_reset = 8'h00;
    localparam logic [7:0] ctrl_wmask = 8'h93;
    localparam logic [2:0] sel_reset = 3'h0;
    localparam logic [3:0] adc_sel_reset = 4'h0;
    // trigger code meaning comparator output
    localparam logic [3:0] adc_sel_cmp = 4'h1;

    // timer clock source codes
    localparam logic [1:0] tsrc_fosc = 2'h0;
    localparam logic [1:0] tsrc_fosc4 = 2'h1;

    typedef struct packed {
        logic enable;
        logic invert;
        logic separation;
        logic sync_mode;
    } ctrl_t;

    typedef struct packed {
        logic rising;
        logic falling;
    } edge_cfg_t;

endpackage

// File: hw/comparator_digital_control.sv
`timescale 1ns/10ps
module comparator_digital_control
    import cmp_pkg::*;
#(
    parameter int num_cmp = 1
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic instr_cycle,
    input wire logic raw_compare,
    input wire logic timer_src_clk,
    input wire logic timer_prescale_en,
    input wire logic timer_prescale_out,
    input wire logic [1:0] timer_src_sel,
    input wire logic sleep_mode,
    output logic analog_enable,
    output logic hysteresis_en,
    output logic [2:0] pos_input_select,
    output logic [2:0] neg_input_select,
    output logic timer_pin_out,
    output logic irq_req,
    output logic wake_req,
    output logic adc_trigger
);

    // the mirror register and the single edge detector serve one comparator
    if (num_cmp != 1)
    begin : g_num_cmp_check
        $error("only one comparator is served");
    end

    ctrl_t ctrl_r;
    edge_cfg_t edge_r;
    logic [2:0] pos_sel_r;
    logic [2:0] neg_sel_r;
    logic [3:0] adc_sel_r;
    logic flag_r;
    logic ie_r;
    logic gie_r;
    logic out_r;
    logic out_prev_r;
    logic tclk_prev_r;
    logic sync_out_r;
    logic pin_out_r;
    logic adc_trig_r;
    logic adj_out;
    logic sync_clk;
    logic sync_fall;
    logic sync_frozen;
    logic rise_evt;
    logic fall_evt;
    logic edge_evt;
    logic wr_en;
    logic rd_en;
    logic mapped;
    logic wr_ctrl;
    logic wr_edge;
    logic wr_pos;
    logic wr_neg;
    logic wr_irq;
    logic wr_adc;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode: zero wait states, unmapped addresses answer slverr

    function automatic logic is_mapped(input logic [15:0] a);
        return a == ctrl_status_addr || a == edge_ctrl_addr || a == neg_sel_addr ||
               a == pos_sel_addr || a == mirror_addr || a == irq_ctrl_addr ||
               a == adc_trig_addr;
    endfunction

    assign mapped = is_mapped(paddr);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign wr_en = psel && penable && pwrite && mapped && pstrb[0];
    assign rd_en = psel && penable && !pwrite;

    // one strobe per register so the address decode is written once
    function automatic logic reg_hit(input logic en, input logic [15:0] a,
                                     input logic [15:0] target);
        return en && a == target;
    endfunction

    assign wr_ctrl = reg_hit(wr_en, paddr, ctrl_status_addr);
    assign wr_edge = reg_hit(wr_en, paddr, edge_ctrl_addr);
    assign wr_pos = reg_hit(wr_en, paddr, pos_sel_addr);
    assign wr_neg = reg_hit(wr_en, paddr, neg_sel_addr);
    assign wr_irq = reg_hit(wr_en, paddr, irq_ctrl_addr);
    assign wr_adc = reg_hit(wr_en, paddr, adc_trig_addr);

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= '0;
        end
        else if (wr_ctrl)
        begin
            ctrl_r.enable <= pwdata[en_bit];
            ctrl_r.invert <= pwdata[inv_bit];
            ctrl_r.separation <= pwdata[sep_bit];
            ctrl_r.sync_mode <= pwdata[sync_bit];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            edge_r <= '0;
        end
        else if (wr_edge)
        begin
            edge_r.rising <= pwdata[rise_bit];
            edge_r.falling <= pwdata[fall_bit];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pos_sel_r <= sel_reset;
            neg_sel_r <= sel_reset;
            adc_sel_r <= adc_sel_reset;
        end
        else if (wr_en)
        begin
            if (wr_pos)
                pos_sel_r <= pwdata[2:0];
            if (wr_neg)
                neg_sel_r <= pwdata[2:0];
            if (wr_adc)
                adc_sel_r <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ie_r <= 1'b0;
            gie_r <= 1'b0;
        end
        else if (wr_irq)
        begin
            ie_r <= pwdata[ie_bit];
            gie_r <= pwdata[gie_bit];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // analog side controls

    assign analog_enable = ctrl_r.enable;
    assign hysteresis_en = ctrl_r.separation;
    assign pos_input_select = ctrl_r.enable ? pos_sel_r : sel_reset;
    assign neg_input_select = ctrl_r.enable ? neg_sel_r : sel_reset;

    ////////////////////////////////////////////////////////////////////////////
    // output path

    // raw_compare is high when noninverting input is higher
    // forced zero while disabled; polarity applied after gating
    // invert still acts when disabled, so it yields an edge
    assign adj_out = (raw_compare & ctrl_r.enable) ^ ctrl_r.invert;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_r <= 1'b0;
            out_prev_r <= 1'b0;
        end
        else if (instr_cycle)
        begin
            out_r <= adj_out;
            out_prev_r <= out_r;
        end
    end

    // prescaler output clocks capture when prescaler used
    // limitation: flipping the prescaler select can fake one falling edge
    assign sync_clk = timer_prescale_en ? timer_prescale_out : timer_src_clk;
    // timer stops in sleep on system-clock sources
    assign sync_frozen = sleep_mode && (timer_src_sel == tsrc_fosc ||
                                        timer_src_sel == tsrc_fosc4);
    assign sync_fall = tclk_prev_r && !sync_clk && !sync_frozen;

    // previous clock resets low so no false falling edge follows reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tclk_prev_r <= 1'b0;
            sync_out_r <= 1'b0;
        end
        else
        begin
            tclk_prev_r <= sync_clk;
            if (sync_fall)
                sync_out_r <= adj_out;
        end
    end

    // data output kept in a flop; one cycle behind the selected source, adj_out or sync_out_r
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_out_r <= 1'b0;
        else
            // direct path when sync off; registered pin path
            pin_out_r <= ctrl_r.sync_mode ? sync_out_r : adj_out;
    end
    assign timer_pin_out = pin_out_r;

    ////////////////////////////////////////////////////////////////////////////
    // edges, flag, wake, adc trigger

    assign rise_evt = instr_cycle && out_r && !out_prev_r;
    assign fall_evt = instr_cycle && !out_r && out_prev_r;
    // edge enables select which edges set the flag
    assign edge_evt = (rise_evt && edge_r.rising) || (fall_evt && edge_r.falling);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flag_r <= 1'b0;
        // set wins over a clear in the same cycle
        else if (edge_evt)
            flag_r <= 1'b1;
        // only a software write of zero clears it
        else if (wr_irq && !pwdata[flag_bit])
            flag_r <= 1'b0;
    end

    // all enables needed for a request
    assign irq_req = flag_r && ie_r && gie_r && ctrl_r.enable;
    // wake needs only the comparator irq enable
    // global enable left out so a masked core still wakes from sleep
    assign wake_req = flag_r && ie_r && sleep_mode;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            adc_trig_r <= 1'b0;
        else
            adc_trig_r <= rise_evt && adc_sel_r == adc_sel_cmp;
    end
    assign adc_trigger = adc_trig_r;

    ////////////////////////////////////////////////////////////////////////////
    // read mux

    always_comb
    begin
        prdata = 32'h0000_0000;
        if (rd_en)
        begin
            unique case (paddr)
                ctrl_status_addr:
                begin
                    prdata[en_bit] = ctrl_r.enable;
                    prdata[out_bit] = out_r;
                    prdata[inv_bit] = ctrl_r.invert;
                    prdata[sep_bit] = ctrl_r.separation;
                    prdata[sync_bit] = ctrl_r.sync_mode;
                end
                edge_ctrl_addr:
                begin
                    prdata[rise_bit] = edge_r.rising;
                    prdata[fall_bit] = edge_r.falling;
                end
                neg_sel_addr: prdata[2:0] = neg_sel_r;
                pos_sel_addr: prdata[2:0] = pos_sel_r;
                // shared output register; bit 0 mirror
                mirror_addr: prdata[0] = out_r;
                irq_ctrl_addr:
                begin
                    prdata[flag_bit] = flag_r;
                    prdata[ie_bit] = ie_r;
                    prdata[gie_bit] = gie_r;
                    prdata[sleep_bit] = sleep_mode;
                end
                adc_trig_addr: prdata[3:0] = adc_sel_r;
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

endmodule

// File: verif/cmp_analog_model.sv
`timescale 1ns/10ps
module cmp_analog_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] vp,
    input wire logic [7:0] vn,
    output logic raw_compare,
    output logic instr_cycle,
    output logic timer_src_clk,
    output logic timer_prescale_out
);
    logic [3:0] div_r;
    // timer clock at /8, prescaler output at /16, instruction pulse at /4
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_r <= 4'h0;
        else
            div_r <= div_r + 4'h1;
    end
    assign instr_cycle = (div_r[1:0] == 2'h3);
    assign timer_src_clk = div_r[2];
    assign timer_prescale_out = div_r[3];
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            raw_compare <= 1'b0;
        else
            raw_compare <= (vp > vn);
    end
endmodule

// File: verif/cmp_digital_properties.sv
`timescale 1ns/10ps
module cmp_digital_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sleep_mode,
    input wire logic analog_enable,
    input wire logic hysteresis_en,
    input wire logic [2:0] pos_input_select,
    input wire logic [2:0] neg_input_select,
    input wire logic irq_req,
    input wire logic wake_req,
    input wire logic adc_trigger
);
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic wr_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wr_r <= 1'b0;
        else
            wr_r <= psel && penable && pwrite;
    end
    sequence adc_pulse;
        adc_trigger ##1 !adc_trigger;
    endsequence
    sel_forced_zero_a:
        assert property (!analog_enable |-> pos_input_select == 3'h0 && neg_input_select == 3'h0)
        else $error("input select not zero while disabled");
    irq_needs_enable_a:
        assert property (irq_req |-> analog_enable) else $error("irq without enable");
    wake_in_sleep_a:
        assert property (wake_req |-> sleep_mode) else $error("wake outside sleep");
    adc_single_pulse_a:
        assert property ($rose(adc_trigger) |-> adc_pulse) else $error("adc trigger not one cycle");
    bus_no_wait_a:
        assert property (psel && penable |-> pready) else $error("pready low in access");
    err_in_access_a:
        assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
    rdata_idle_zero_a:
        assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
        else $error("prdata not zero when idle");
    flag_sticky_a:
        assert property ($fell(irq_req) |-> wr_r) else $error("irq dropped without write");
    sep_by_write_a:
        assert property ($changed(hysteresis_en) |-> wr_r) else $error("hysteresis moved alone");
    enable_by_write_a:
        assert property ($changed(analog_enable) |-> wr_r) else $error("enable moved alone");
endmodule
////////////////////////////////////////////////////////////////
bind comparator_digital_control cmp_digital_properties u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
    .analog_enable(analog_enable), .hysteresis_en(hysteresis_en),
    .pos_input_select(pos_input_select), .neg_input_select(neg_input_select),
    .irq_req(irq_req), .wake_req(wake_req), .adc_trigger(adc_trigger)
);

// File: verif/test_comparator_digital_control.sv
`timescale 1ns/10ps
module test_comparator_digital_control;
    import cmp_pkg::*;
    typedef struct packed {logic inv; logic hi; logic exp;} row_t;
    row_t rows [4] = '{'{1'b0, 1'b1, 1'b1}, '{1'b0, 1'b0, 1'b0}, '{1'b1, 1'b1, 1'b0},
        '{1'b1, 1'b0, 1'b1}};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tpe = 1'b0, sleep_mode = 1'b0, err;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [1:0] tsel = 2'h2;
    logic [7:0] vp = 8'h0, vn = 8'h8;
    logic pready, pslverr, instr_cycle, raw_compare, tclk, tpo, analog_enable, hysteresis_en;
    logic timer_pin_out, irq_req, wake_req, adc_trigger;
    logic [2:0] pos_sel, neg_sel;
    int fail_count = 0, n_tests = 0, adc_cnt = 0, a0;
    always #2 pclk = ~pclk;
    always @(posedge pclk) adc_cnt <= adc_cnt + adc_trigger;
    cmp_analog_model u_model (.pclk(pclk), .presetn(presetn), .vp(vp), .vn(vn),
        .raw_compare(raw_compare), .instr_cycle(instr_cycle), .timer_src_clk(tclk),
        .timer_prescale_out(tpo));
    comparator_digital_control #(.num_cmp(1)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instr_cycle(instr_cycle), .raw_compare(raw_compare), .timer_src_clk(tclk),
        .timer_prescale_en(tpe), .timer_prescale_out(tpo), .timer_src_sel(tsel),
        .sleep_mode(sleep_mode), .analog_enable(analog_enable), .hysteresis_en(hysteresis_en),
        .pos_input_select(pos_sel), .neg_input_select(neg_sel),
        .timer_pin_out(timer_pin_out), .irq_req(irq_req), .wake_req(wake_req),
        .adc_trigger(adc_trigger));
    ////////////////////////////////////////////////////////////////
    task finish_test;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until pready is sampled high at a rising edge, data taken there
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task settle;
        repeat (24) @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        #20000;
        fail_count++;
        finish_test;
    end
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ctrl_status_addr, 32'h0);
        chk(rd, 32'h0);
        chk({hysteresis_en, analog_enable}, 32'h0);
        apb(1'b1, pos_sel_addr, 32'h5);
        apb(1'b1, neg_sel_addr, 32'h6);
        vp <= 8'h10;
        settle;
        apb(1'b0, ctrl_status_addr, 32'h0);
        chk(rd, 32'h0);
        chk(pos_sel, 32'h0);
        chk(neg_sel, 32'h0);
        foreach (rows[i])
        begin
            vp <= rows[i].hi ? 8'h10 : 8'h0;
            apb(1'b1, ctrl_status_addr, {rows[i].inv, 4'h0} | 32'h80);
            settle;
            apb(1'b0, ctrl_status_addr, 32'h0);
            chk(rd[out_bit], rows[i].exp);
            apb(1'b0, mirror_addr, 32'h0);
            chk(rd, rows[i].exp);
            chk(timer_pin_out, rows[i].exp);
        end
        chk(pos_sel, 32'h5);
        chk(neg_sel, 32'h6);
        apb(1'b1, ctrl_status_addr, 32'hbf);
        settle;
        apb(1'b0, ctrl_status_addr, 32'h0);
        chk(rd, 32'hd3);
        chk({hysteresis_en, analog_enable}, 32'h3);
        apb(1'b1, 16'h1090, 32'hff);
        chk(err, 32'h1);
        apb(1'b1, ctrl_status_addr, 32'h80);
        apb(1'b1, adc_trig_addr, {28'h0, adc_sel_cmp});
        apb(1'b1, edge_ctrl_addr, 32'h2);
        apb(1'b1, irq_ctrl_addr, 32'h6);
        a0 = adc_cnt;
        vp <= 8'h10;
        settle;
        chk(irq_req, 32'h1);
        vp <= 8'h0;
        settle;
        apb(1'b0, irq_ctrl_addr, 32'h0);
        chk(rd[flag_bit], 32'h1);
        chk(adc_cnt - a0, 32'h1);
        apb(1'b1, irq_ctrl_addr, 32'h6);
        @(posedge pclk);
        chk(irq_req, 32'h0);
        apb(1'b1, edge_ctrl_addr, 32'h1);
        vp <= 8'h10;
        settle;
        chk(irq_req, 32'h0);
        vp <= 8'h0;
        settle;
        chk(irq_req, 32'h1);
        apb(1'b1, irq_ctrl_addr, 32'h6);
        apb(1'b1, edge_ctrl_addr, 32'h2);
        apb(1'b1, ctrl_status_addr, 32'h0);
        sleep_mode <= 1'b1;
        apb(1'b1, ctrl_status_addr, 32'h10);
        settle;
        chk(wake_req, 32'h1);
        chk(irq_req, 32'h0);
        apb(1'b0, irq_ctrl_addr, 32'h0);
        chk(rd[flag_bit], 32'h1);
        tsel <= tsrc_fosc;
        tpe <= 1'b1;
        apb(1'b1, ctrl_status_addr, 32'h81);
        settle;
        chk(timer_pin_out, 32'h1);
        tsel <= tsrc_fosc4;
        settle;
        chk(timer_pin_out, 32'h1);
        sleep_mode <= 1'b0;
        settle;
        chk(timer_pin_out, 32'h0);
        finish_test;
    end
endmodule
